// file: rtl/udwc_defines.vh
`ifndef UDWC_DEFINES_VH
`define UDWC_DEFINES_VH

// ****************************************************************
// Timing figures as printed, and the clock they are counted against.
// ****************************************************************
`define UDWC_CLK_NS          50
`define UDWC_T_SETUP_NS      100
`define UDWC_T_STROBE_NS     1000
`define UDWC_T_GAP_NS        1000
`define UDWC_T_DESEL_NS      250
`define UDWC_T_DESEL_ST_MS   10
`define UDWC_NS_PER_MS       1000000
`define UDWC_T_DESEL_ST_NS   (`UDWC_T_DESEL_ST_MS * `UDWC_NS_PER_MS)

// Least times round up to whole cycles.
`define UDWC_CYC(ns) (((ns) + `UDWC_CLK_NS - 1) / `UDWC_CLK_NS)

// ****************************************************************
// Command codes.
// ****************************************************************
`define UDWC_CMD_DOWN   2'h0
`define UDWC_CMD_UP     2'h1
`define UDWC_CMD_STORE  2'h2
`define UDWC_CMD_DROP   2'h3

`endif

// file: rtl/udwc_timer.v
`timescale 1ns/1ps
// ****************************************************************
// Down counter that reports when a loaded wait has elapsed.
// ****************************************************************
module udwc_timer #(
  parameter WIDTH = 18
) (
  input  wire             clk,      // System clock.
  input  wire             reset_n,  // Synchronous reset, active low.
  input  wire             load,     // Load a new wait this cycle.
  input  wire [WIDTH-1:0] count,    // Cycles to wait, at least one.
  output wire             done      // High while no wait is running.
);

  reg [WIDTH-1:0] cnt_r;

  // Loading count N keeps done low for exactly N cycles.
  always @(posedge clk) begin
    if (!reset_n) begin
      cnt_r <= {WIDTH{1'b0}};
    end else if (load) begin
      cnt_r <= count;
    end else if (cnt_r != {WIDTH{1'b0}}) begin
      cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign done = (cnt_r == {WIDTH{1'b0}});

endmodule

// file: rtl/udwc_host.v
`timescale 1ns/1ps
`include "udwc_defines.vh"
// Contract
// - Raising select with the strobe low leaves the stored value alone.
// - The host holds select high from reset until a store or a nonzero step command.
// - After a store deselect, select stays high at least 10 ms.
// - After a plain deselect, select stays high at least 250 ns.
// - Select rises at least 1 us after the strobe's final level.
// - Direction may change while select stays low.
module udwc_host #(
  parameter STORE_WAIT = `UDWC_CYC(`UDWC_T_DESEL_ST_NS),  // Store hold.
  parameter TW         = 18       // Width of the wait timer.
) (
  input  wire       clk,        // System clock, 20 MHz.
  input  wire       reset_n,    // Synchronous reset, active low.
  input  wire       cmdValid,   // Command request.
  input  wire [1:0] cmdOp,      // Command code.
  input  wire [5:0] cmdSteps,   // Steps for up or down, 0 to 32.
  output reg        cmdReady,   // Idle and able to take a command.
  output reg        selectN,    // Select pin, active low.
  output reg        strobeN,    // Step strobe pin, active low edge.
  output reg        upDir,      // Direction pin, high moves up.
  output reg  [4:0] position,   // Mirrored wiper position.
  output reg        posKnown    // Set by a store release; cleared only by reset.
);

  // ****************************************************************
  // Timing counts.
  // ****************************************************************
  // Counts are worked out as integers, then cut to the timer width.
  localparam integer  N_SETUP  = `UDWC_CYC(`UDWC_T_SETUP_NS);
  localparam integer  N_STROBE = `UDWC_CYC(`UDWC_T_STROBE_NS);
  localparam integer  N_GAP    = `UDWC_CYC(`UDWC_T_GAP_NS);
  localparam integer  N_DESEL  = `UDWC_CYC(`UDWC_T_DESEL_NS);
  localparam integer  N_STWAIT = STORE_WAIT;
  localparam [TW-1:0] C_SETUP  = N_SETUP[TW-1:0];
  localparam [TW-1:0] C_STROBE = N_STROBE[TW-1:0];
  localparam [TW-1:0] C_GAP    = N_GAP[TW-1:0];
  localparam [TW-1:0] C_DESEL  = N_DESEL[TW-1:0];
  localparam [TW-1:0] C_STWAIT = N_STWAIT[TW-1:0];
  localparam [4:0]    POS_MAX  = 5'h1F;

  // ****************************************************************
  // States.
  // ****************************************************************
  localparam S_IDLE = 3'h0;
  localparam S_SEL  = 3'h1;
  localparam S_LOW  = 3'h2;
  localparam S_HIGH = 3'h3;
  localparam S_END  = 3'h4;
  localparam S_REST = 3'h5;

  // ****************************************************************
  // Registers.
  // ****************************************************************
  reg  [2:0]    state_r;
  reg  [2:0]    state_nxt;
  reg  [1:0]    op_r;
  reg  [5:0]    left_r;
  reg           store_r;
  reg           tLoad;
  reg  [TW-1:0] tCount;
  wire          tDone;

  // ****************************************************************
  // Wait timer.
  // ****************************************************************
  udwc_timer #(.WIDTH(TW)) uTimer (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (tLoad),
    .count   (tCount),
    .done    (tDone)
  );

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  // Next state and timer loads.
  always @* begin
    state_nxt = state_r;
    tLoad     = 1'b0;
    tCount    = C_SETUP;
    case (state_r)
      S_IDLE: begin
        if (cmdValid && cmdReady) begin
          state_nxt = (cmdOp[1]) ? S_END : S_SEL;
          tCount    = cmdOp[1] ? C_GAP : (strobeN ? C_SETUP : C_STROBE);
          tLoad     = 1'b1;
        end
      end
      S_SEL: begin
        if (tDone) begin
          state_nxt = (left_r == 6'h00) ? S_IDLE : S_LOW;
          tCount    = C_STROBE;
          tLoad     = (left_r != 6'h00);
        end
      end
      S_LOW: begin
        if (tDone) begin
          // The last step leaves the strobe low for a plain release.
          state_nxt = (left_r == 6'h00) ? S_IDLE : S_HIGH;
          tCount    = C_STROBE;
          tLoad     = (left_r != 6'h00);
        end
      end
      S_HIGH: begin
        if (tDone) begin
          state_nxt = (left_r == 6'h00) ? S_IDLE : S_LOW;
          tCount    = C_STROBE;
          tLoad     = (left_r != 6'h00);
        end
      end
      S_END: begin
        if (tDone) begin
          state_nxt = S_REST;
          tCount    = store_r ? C_STWAIT : C_DESEL;
          tLoad     = 1'b1;
        end
      end
      S_REST: begin
        if (tDone) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Pins and mirror.
  // ****************************************************************
  // Pin drive, mirror and bookkeeping.
  always @(posedge clk) begin
    if (!reset_n) begin
      state_r  <= S_IDLE;
      op_r     <= `UDWC_CMD_DOWN;
      left_r   <= 6'h00;
      store_r  <= 1'b0;
      cmdReady <= 1'b0;
      selectN  <= 1'b1;
      strobeN  <= 1'b1;
      upDir    <= 1'b0;
      position <= 5'h00;
      posKnown <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cmdReady <= (state_nxt == S_IDLE);
      case (state_r)
        S_IDLE: begin
          if (cmdValid && cmdReady) begin
            op_r    <= cmdOp;
            left_r  <= cmdSteps;
            store_r <= (cmdOp == `UDWC_CMD_STORE);
            if (!cmdOp[1]) begin
              // Select with the strobe high, direction set early. A
              // zero-step command moves no pin but the direction.
              upDir <= (cmdOp == `UDWC_CMD_UP);
              if (cmdSteps != 6'h00) begin
                selectN <= 1'b0;
                strobeN <= 1'b1;
              end
            end else if (cmdOp == `UDWC_CMD_STORE) begin
              // The strobe must be high when select rises.
              selectN <= 1'b0;
              strobeN <= 1'b1;
            end
            // A drop needs no pin here: every step ends with the strobe
            // low, so a held select already has it low, and a released
            // select has nothing to release.
          end
        end
        S_LOW, S_SEL, S_HIGH: begin
          if (tDone && (state_nxt == S_LOW)) begin
            strobeN <= 1'b0;
            left_r  <= left_r - 6'h01;
            if (op_r == `UDWC_CMD_UP) begin
              if (position != POS_MAX) begin
                position <= position + 5'h01;
              end
            end else if (position != 5'h00) begin
              position <= position - 5'h01;
            end
          end else if (tDone && (state_nxt == S_HIGH)) begin
            strobeN <= 1'b1;
          end
        end
        S_END: begin
          // Select rises only after the strobe held its level.
          if (tDone) begin
            // The strobe keeps its level, which picks store or not.
            selectN <= 1'b1;
            if (store_r) begin
              posKnown <= 1'b1;
            end
          end
        end
        S_REST: begin
          // Released and resting; the strobe returns high only at the
          // end, so no edge reaches a part that is still writing.
          if (tDone) begin
            strobeN <= 1'b1;
          end
        end
        default: begin
          strobeN <= strobeN;
        end
      endcase
    end
  end

  // The mirror starts at zero, not at the recalled position; a
  // saturating sync of 32 down steps pins both to tap zero, which is
  // how a user learns the true position after power-up.

endmodule

// file: testbench/udwc_host_asserts.sv
`timescale 1ns/1ps
// ****
// Pin timing checks for the host.
// ****
module udwc_host_asserts #(
  parameter STORE_WAIT = 200000  // Store hold.
) (
  input wire       clk,       // Clock.
  input wire       reset_n,   // Reset.
  input wire       cmdValid,  // Request.
  input wire [1:0] cmdOp,     // Code.
  input wire       cmdReady,  // Idle.
  input wire       selectN,   // Select.
  input wire       strobeN,   // Strobe.
  input wire       upDir,     // Direction.
  input wire [4:0] position   // Mirror.
);
  reg [17:0] hiCnt_r;   // Select high time.
  reg        stored_r;  // Last release stored.
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Reset counts as a long release, so the first select is legal.
  always @(posedge clk) begin
    if (!reset_n) hiCnt_r <= 18'h3FFFF;
    else if (!selectN) hiCnt_r <= 18'h00000;
    else if (~&hiCnt_r) hiCnt_r <= hiCnt_r + 18'h00001;
    if (!reset_n) stored_r <= 1'b0;
    else if ($rose(selectN)) stored_r <= strobeN;
  end
  a_reset_idle:
    assert property ($rose(reset_n) |-> selectN && strobeN)
    else $error("pins active after reset");
  a_step_selected:
    assert property ($fell(strobeN) |-> !selectN && $past(!selectN, 2))
    else $error("step while not selected");
  a_up_step:
    assert property ($fell(strobeN) && upDir |-> position ==
      ($past(position) == 5'h1F ? 5'h1F : $past(position) + 5'h01))
    else $error("bad up step");
  a_down_step:
    assert property ($fell(strobeN) && !upDir |-> position ==
      ($past(position) == 5'h00 ? 5'h00 : $past(position) - 5'h01))
    else $error("bad down step");
  a_gap_before:
    assert property ($rose(selectN) |-> strobeN == $past(strobeN, 20))
    else $error("release too soon");
  a_store_gap:
    assert property ($fell(selectN) && stored_r |-> hiCnt_r >= STORE_WAIT)
    else $error("reselect after store too soon");
  a_drop_gap:
    assert property ($fell(selectN) |-> hiCnt_r >= 18'h00005)
    else $error("reselect too soon");
  a_store_op:
    assert property (cmdValid && cmdReady && cmdOp == 2'h2 |->
      ##[1:100] $rose(selectN) && strobeN)
    else $error("store release missing");
  a_drop_op:
    assert property (cmdValid && cmdReady && cmdOp == 2'h3 && !selectN |->
      ##[1:100] $rose(selectN) && !strobeN)
    else $error("drop release with strobe high");
endmodule
bind udwc_host udwc_host_asserts #(.STORE_WAIT(STORE_WAIT)) udwcChk (
  .clk(clk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdOp(cmdOp),
  .cmdReady(cmdReady), .selectN(selectN), .strobeN(strobeN),
  .upDir(upDir), .position(position));

// file: testbench/udwc_pot_model.sv
`timescale 1ns/1ps
// ****
// Pot model: step counter and stored copy.
// ****
module udwc_pot_model #(
  parameter WRITE_NS = 1000  // Store time.
) (
  input  wire        powerOn,          // Supply up.
  input  wire        selectN,          // Select.
  input  wire        strobeN,          // Strobe.
  input  wire        upDir,            // Direction.
  output reg  [4:0]  wiper = 5'h00,    // Count.
  output reg  [4:0]  nvValue = 5'h00,  // Stored.
  output wire [31:0] tap               // Taps.
);
  reg       busy_r = 1'b0;
  reg [4:0] nvHold = 5'h00;  // Count taken at the release.
  // One closed switch per count.
  assign tap = 32'h00000001 << wiper;
  // Power-up drops any unstored move.
  always @(posedge powerOn) wiper = nvValue;
  // Selected falls step, clamped at the ends.
  always @(negedge strobeN) begin
    if (powerOn && !selectN && !busy_r) begin
      if (upDir && wiper != 5'h1F) wiper = wiper + 5'h01;
      if (!upDir && wiper != 5'h00) wiper = wiper - 5'h01;
    end
  end
  // Release with strobe high stores, then stands by.
  always @(posedge selectN) begin
    if (powerOn && strobeN) begin
      busy_r = 1'b1;
      nvHold = wiper;
      #WRITE_NS nvValue = nvHold;
      busy_r = 1'b0;
    end
  end
endmodule

// file: testbench/udwc_host_bench.sv
`timescale 1ns/1ps
// ****
// Bench: table of commands, then power cycle and reset.
// ****
module udwc_host_bench;
  typedef struct packed {
    logic [1:0] op;
    logic [5:0] n;
    logic [4:0] pos;
    logic [4:0] nv;
  } udwc_row_t;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       cmdValid = 1'b0;
  logic [1:0] cmdOp = 2'h0;
  logic [5:0] cmdSteps = 6'h00;
  logic       powerOn = 1'b0;
  wire        cmdReady, selectN, strobeN, upDir, posKnown;
  wire  [4:0] position, wiper, nvValue;
  int         failures = 0;
  int         n_checks = 0;
  udwc_row_t  rows [6] = '{'{2'h1, 6'h03, 5'h03, 5'h00},
    '{2'h0, 6'h01, 5'h02, 5'h00}, '{2'h1, 6'h20, 5'h1F, 5'h00},
    '{2'h2, 6'h00, 5'h1F, 5'h1F}, '{2'h0, 6'h20, 5'h00, 5'h1F},
    '{2'h3, 6'h00, 5'h00, 5'h1F}};
  udwc_host #(.STORE_WAIT(50)) DUT (.clk(clk), .reset_n(reset_n),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSteps(cmdSteps),
    .cmdReady(cmdReady), .selectN(selectN), .strobeN(strobeN),
    .upDir(upDir), .position(position), .posKnown(posKnown));
  udwc_pot_model #(.WRITE_NS(2000)) pot (.powerOn(powerOn),
    .selectN(selectN), .strobeN(strobeN), .upDir(upDir),
    .wiper(wiper), .nvValue(nvValue), .tap());
  always #25 clk = ~clk;
  task end_sim;
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // Bounded wait for idle; a hang ends the run.
  task idle;
    for (int i = 0; cmdReady !== 1'b1; i++) begin
      if (i == 5000) begin
        chk("cmdReady", 5'h01, {4'h0, cmdReady});
        end_sim;
      end
      @(negedge clk);
    end
  endtask
  task run(input logic [1:0] op, input logic [5:0] n);
    idle;
    cmdValid = 1'b1;
    cmdOp = op;
    cmdSteps = n;
    @(negedge clk);
    cmdValid = 1'b0;
    @(negedge clk);
    idle;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    chk("selectN", 5'h01, {4'h0, selectN});
    reset_n = 1'b1;
    powerOn = 1'b1;
    for (int r = 0; r < 6; r++) begin
      run(rows[r].op, rows[r].n);
      chk("position", rows[r].pos, position);
      chk("wiper", rows[r].pos, wiper);
      chk("nvValue", rows[r].nv, nvValue);
    end
    // Power cycle brings back the stored count, not the unstored one.
    powerOn = 1'b0;
    @(negedge clk);
    powerOn = 1'b1;
    @(negedge clk);
    chk("wiper", 5'h1F, wiper);
    reset_n = 1'b0;
    repeat (8) @(negedge clk);
    chk("position", 5'h00, position);
    chk("posKnown", 5'h00, {4'h0, posKnown});
    reset_n = 1'b1;
    // Store then reselect at once; the hold gap is watched.
    run(2'h0, 6'h01);
    run(2'h2, 6'h00);
    run(2'h0, 6'h01);
    chk("wiper", 5'h1D, wiper);
    chk("nvValue", 5'h1E, nvValue);
    chk("posKnown", 5'h01, {4'h0, posKnown});
    // Zero steps move nothing; a plain release keeps the stored copy.
    run(2'h1, 6'h00);
    run(2'h3, 6'h00);
    run(2'h3, 6'h00);
    run(2'h0, 6'h00);
    chk("selectN", 5'h01, {4'h0, selectN});
    chk("upDir", 5'h00, {4'h0, upDir});
    chk("wiper", 5'h1D, wiper);
    chk("nvValue", 5'h1E, nvValue);
    powerOn = 1'b0;
    @(negedge clk);
    powerOn = 1'b1;
    @(negedge clk);
    chk("wiper", 5'h1E, wiper);
    end_sim;
  end
endmodule
